// *** clock_serial_config.sv ***
// clock generator and serial slave configuration bank, AXI4-Lite slave
`timescale 1ns/1ps
module clock_serial_config #(
  parameter int ADDR_W         = 10,
  parameter bit HAS_SERIAL_BUS = 1'b1,
  parameter int SLOW_FAST_HALF = clkcfg_pkg::SLOW_32K_HALF_CYC,
  parameter int SLOW_ONE_HALF  = clkcfg_pkg::SLOW_1HZ_HALF_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              standby_reset_n,
  input  wire logic              battery_reset_n,
  input  wire logic              ext_clock_strap_pin,
  input  wire logic              multiplier_locked_pin,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   slow_clock_out_pin,
  output logic                   fast_clock_out_pin,
  output logic                   fast_base_is_48m,
  output logic                   serial_pullup_enable,
  output logic [6:0]             serial_slave_addr
);
  import clkcfg_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  generate
    if (ADDR_W < 10) begin : g_bad_addr
      $error("ADDR_W must reach the highest register address");
    end
    if (SLOW_FAST_HALF < 1 || SLOW_ONE_HALF < 1 ||
        SLOW_ONE_HALF > 33554431) begin : g_bad_slow
      $error("slow clock half periods out of range");
    end
  endgenerate

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic reg_sel_type reg_sel(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(CLOCK_CONFIG_ADDR))
      reg_sel = SEL_CLOCK;
    else if (a == ADDR_W'(SERIAL_CONFIG_ADDR))
      reg_sel = SEL_SERIAL;
    else if (a == ADDR_W'(SERIAL_LOCK_CTL_ADDR))
      reg_sel = SEL_LOCK;
    else
      reg_sel = SEL_NONE;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [SYNC_STAGES-1:0] strap_sync_reg;
  logic [SYNC_STAGES-1:0] mult_sync_reg;
  logic                   strap_level_reg;
  logic                   mult_good_reg;

  // a change counts only once the last two stages agree
  always_ff @(posedge aclk) begin
    strap_sync_reg <= {strap_sync_reg[1:0], ext_clock_strap_pin};
    mult_sync_reg  <= {mult_sync_reg[1:0], multiplier_locked_pin};
    if (!standby_reset_n) begin
      mult_good_reg <= 1'b0;
    end else if (mult_sync_reg[1] == mult_sync_reg[2]) begin
      mult_good_reg <= mult_sync_reg[2];
    end
    if (strap_sync_reg[1] == strap_sync_reg[2]) begin
      strap_level_reg <= strap_sync_reg[2];
    end
  end

  // ****************************************************************
  // write channel
  // ****************************************************************
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0]        wdata_reg;
  logic              wlane0_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;

  wire         aw_take  = s_axi_awvalid && !aw_have_reg;
  wire         w_take   = s_axi_wvalid && !w_have_reg;
  wire         wr_fire  = aw_have_reg && w_have_reg && !bvalid_reg;
  reg_sel_type wr_sel;
  assign wr_sel = reg_sel(awaddr_reg);
  wire         wr_byte  = wr_fire && wlane0_reg;
  wire         wr_clock = wr_byte && (wr_sel == SEL_CLOCK);
  wire         wr_ser   = wr_byte && (wr_sel == SEL_SERIAL);
  wire         wr_lock  = wr_byte && (wr_sel == SEL_LOCK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 8'h00;
      wlane0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wlane0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        // locked or spent registers still answer okay
        bresp_reg   <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready  = !w_have_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // ****************************************************************
  // clock generator configuration, standby well
  // ****************************************************************
  logic       lock_reg;
  logic       domain_reg;
  logic       slow_sel_reg;
  logic       fast_off_reg;
  logic [2:0] divisor_reg;
  logic       strap_reg;

  wire        clk_writable = wr_clock && !lock_reg;

  // strap caught by the clock while standby reset is held
  always_ff @(posedge aclk) begin
    if (!standby_reset_n) begin
      domain_reg   <= 1'b0;
      slow_sel_reg <= 1'b0;
      fast_off_reg <= 1'b0;
      strap_reg    <= strap_level_reg;
      divisor_reg  <= strap_level_reg ? DIV_RESET_STRAP1
                                      : DIV_RESET_STRAP0;
    end else begin
      if (wr_lock) begin
        domain_reg <= wdata_reg[LCK_DOMAIN_BIT];
      end
      if (clk_writable) begin
        slow_sel_reg <= wdata_reg[CLK_SLOW_SEL_BIT];
        fast_off_reg <= wdata_reg[CLK_FAST_OFF_BIT];
        divisor_reg  <= wdata_reg[CLK_DIV_MSB:0];
      end
    end
  end

  // main reset clears the lock only when the domain selects it
  wire lock_clear = !standby_reset_n ||
                    (!aresetn && !domain_reg);

  always_ff @(posedge aclk) begin
    if (lock_clear) begin
      lock_reg <= 1'b0;
    end else if (wr_lock && wdata_reg[LCK_UNLOCK_BIT]) begin
      lock_reg <= 1'b0;
    end else if (clk_writable && wdata_reg[CLK_LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // serial slave configuration, battery well
  // ****************************************************************
  logic [7:0] serial_cfg_reg;
  logic       serial_done_reg;

  always_ff @(posedge aclk) begin
    if (!battery_reset_n) begin
      serial_cfg_reg  <= SERIAL_CONFIG_RESET;
      serial_done_reg <= 1'b0;
    end else if (wr_ser && !serial_done_reg && HAS_SERIAL_BUS) begin
      serial_cfg_reg  <= wdata_reg;
      serial_done_reg <= 1'b1;
    end
  end

  assign serial_pullup_enable = serial_cfg_reg[SER_PULLUP_BIT];
  assign serial_slave_addr    = serial_cfg_reg[SER_ADDR_MSB:0];

  // ****************************************************************
  // read channel
  // ****************************************************************
  logic        rvalid_reg;
  logic [7:0]  rdata_reg;
  logic [1:0]  rresp_reg;
  reg_sel_type rd_sel;
  assign rd_sel = reg_sel(s_axi_araddr);

  wire  [7:0] clock_view = {lock_reg, slow_sel_reg, fast_off_reg,
                            mult_good_reg, strap_reg, divisor_reg};
  wire  [7:0] lock_view  = {7'h00, domain_reg};
  wire  [7:0] rd_value   = (rd_sel == SEL_CLOCK)  ? clock_view :
                           (rd_sel == SEL_SERIAL) ? serial_cfg_reg :
                           (rd_sel == SEL_LOCK)   ? lock_view : 8'h00;
  wire        ar_take    = s_axi_arvalid && !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_value;
      rresp_reg  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};
  assign s_axi_rresp   = rresp_reg;

  // ****************************************************************
  // slow clock output
  // ****************************************************************
  logic [24:0] slow_count_reg;
  logic        slow_pin_reg;
  wire  [24:0] slow_half = slow_sel_reg ? 25'(SLOW_ONE_HALF)
                                        : 25'(SLOW_FAST_HALF);
  wire         slow_wrap = (slow_count_reg + 25'h1) >= slow_half;

  always_ff @(posedge aclk) begin
    if (!standby_reset_n) begin
      slow_count_reg <= 25'h0;
      slow_pin_reg   <= 1'b0;
    end else if (slow_wrap) begin
      slow_count_reg <= 25'h0;
      slow_pin_reg   <= !slow_pin_reg;
    end else begin
      slow_count_reg <= slow_count_reg + 25'h1;
    end
  end

  assign slow_clock_out_pin = slow_pin_reg;

  // ****************************************************************
  // fast clock output
  // ****************************************************************
  fast_clk_if fc ();

  assign fc.off     = fast_off_reg;
  assign fc.divisor = divisor_reg;

  // aclk stands in for the multiplier output; the strap names its rate
  fast_clk_divider u_fast_div (
    .aclk    (aclk),
    .aresetn (standby_reset_n),
    .fc      (fc.gen)
  );

  assign fast_clock_out_pin = fc.pin;
  assign fast_base_is_48m   = strap_reg;
endmodule

// *** clkcfg_pkg.sv ***
// constants shared by the clock and serial configuration bank
package clkcfg_pkg;
  // ****************************************************************
  // register indexes and byte addresses
  // ****************************************************************
  localparam logic [7:0] CLOCK_CONFIG_IDX = 8'h29;
  localparam logic [7:0] SERIAL_CONFIG_IDX = 8'h2a;
  localparam logic [7:0] SERIAL_LOCK_CTL_IDX = 8'h2b;
  localparam logic [9:0] CLOCK_CONFIG_ADDR = {CLOCK_CONFIG_IDX, 2'b00};
  localparam logic [9:0] SERIAL_CONFIG_ADDR = {SERIAL_CONFIG_IDX, 2'b00};
  localparam logic [9:0] SERIAL_LOCK_CTL_ADDR = {SERIAL_LOCK_CTL_IDX, 2'b00};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CLK_LOCK_BIT = 7;
  localparam int CLK_SLOW_SEL_BIT = 6;
  localparam int CLK_FAST_OFF_BIT = 5;
  localparam int CLK_MULT_GOOD_BIT = 4;
  localparam int CLK_STRAP_BIT = 3;
  localparam int CLK_DIV_MSB = 2;
  localparam int SER_PULLUP_BIT = 7;
  localparam int SER_ADDR_MSB = 6;
  localparam int LCK_DOMAIN_BIT = 0;
  localparam int LCK_UNLOCK_BIT = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [2:0] DIV_RESET_STRAP1 = 3'h0;
  localparam logic [2:0] DIV_RESET_STRAP0 = 3'h1;
  localparam logic [7:0] SERIAL_CONFIG_RESET = 8'h00;

  // ****************************************************************
  // bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_HZ = 40000000;
  localparam longint SLOW_FAST_HZ_X1000 = 32768000;
  localparam longint SLOW_ONE_HZ = 1;
  localparam int SLOW_32K_HALF_CYC =
    int'((CLK_HZ * 1000) / (2 * SLOW_FAST_HZ_X1000));
  localparam int SLOW_1HZ_HALF_CYC = int'(CLK_HZ / (2 * SLOW_ONE_HZ));
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_CLOCK  = 2'b01,
    SEL_SERIAL = 2'b10,
    SEL_LOCK   = 2'b11
  } reg_sel_type;
endpackage

// *** fast_clk_if.sv ***
// control and output of the fast clock divider
`timescale 1ns/1ps
interface fast_clk_if;
  logic       off;
  logic [2:0] divisor;
  logic       pin;
  modport ctrl (output off, output divisor, input pin);
  modport gen (input off, input divisor, output pin);
endinterface

// *** fast_clk_divider.sv ***
// programmable divider that makes the fast clock output
`timescale 1ns/1ps
module fast_clk_divider (
  input  wire logic aclk,
  input  wire logic aresetn,
  fast_clk_if.gen   fc
);
  import clkcfg_pkg::*;

  // ****************************************************************
  // divisor decode
  // ****************************************************************
  function automatic logic [4:0] div_ratio(input logic [2:0] code);
    unique case (code)
      3'h0: div_ratio = 5'h01;
      3'h1: div_ratio = 5'h02;
      3'h2: div_ratio = 5'h03;
      3'h3: div_ratio = 5'h04;
      3'h4: div_ratio = 5'h06;
      3'h5: div_ratio = 5'h08;
      3'h6: div_ratio = 5'h0c;
      3'h7: div_ratio = 5'h10;
    endcase
  endfunction

  logic [4:0] count_reg;
  logic       pin_reg;
  wire  [4:0] ratio     = div_ratio(fc.divisor);
  wire  [4:0] high_len  = 5'((ratio + 5'h01) >> 1);
  wire        last      = (count_reg + 5'h01) >= ratio;
  wire  [4:0] count_next = last ? 5'h00 : count_reg + 5'h01;

  // counter held at zero while disabled to save power
  always_ff @(posedge aclk) begin
    if (!aresetn || fc.off) begin
      count_reg <= 5'h00;
      pin_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      pin_reg   <= count_next < high_len;
    end
  end

  assign fc.pin = pin_reg;
endmodule

// *** clock_serial_config_checker.sv ***
// port assertions for the clock and serial configuration bank
`timescale 1ns/1ps
module clock_serial_config_checker
  import clkcfg_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              standby_reset_n,
  input wire logic              battery_reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              slow_clock_out_pin,
  input wire logic              fast_clock_out_pin,
  input wire logic              fast_base_is_48m,
  input wire logic              serial_pullup_enable,
  input wire logic [6:0]        serial_slave_addr
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              spent_reg;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_mapped = s_axi_araddr == ADDR_W'(CLOCK_CONFIG_ADDR) ||
    s_axi_araddr == ADDR_W'(SERIAL_CONFIG_ADDR) ||
    s_axi_araddr == ADDR_W'(SERIAL_LOCK_CTL_ADDR);
  // serial register only ever written with full strobes by the bench
  wire ser_done = s_axi_bvalid && s_axi_bready &&
    aw_addr_reg == ADDR_W'(SERIAL_CONFIG_ADDR);
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_addr_reg <= s_axi_awaddr;
    spent_reg <= battery_reset_n && (spent_reg || ser_done);
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write answer dropped early");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read answer dropped early");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late");
  property p_rd_mapped;
    ar_take && rd_mapped |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY &&
      s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_mapped: assert property (p_rd_mapped)
    else $error("mapped read answer wrong");
  property p_rd_unmapped;
    ar_take && !rd_mapped |=> s_axi_rvalid &&
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read answer wrong");
  property p_standby_pins;
    !standby_reset_n |=> !fast_clock_out_pin && !slow_clock_out_pin;
  endproperty
  a_standby_pins: assert property (p_standby_pins)
    else $error("clock pins not low in standby reset");
  property p_strap_capture;
    $changed(fast_base_is_48m) |-> !$past(standby_reset_n);
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("strap changed outside standby reset");
  property p_serial_once;
    disable iff (!battery_reset_n)
    spent_reg |=> $stable({serial_pullup_enable, serial_slave_addr});
  endproperty
  a_serial_once: assert property (p_serial_once)
    else $error("serial setting changed after first write");
endmodule

bind clock_serial_config clock_serial_config_checker #(.ADDR_W(ADDR_W)) chk_i (
  .aclk(aclk), .aresetn(aresetn), .standby_reset_n(standby_reset_n),
  .battery_reset_n(battery_reset_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .slow_clock_out_pin(slow_clock_out_pin),
  .fast_clock_out_pin(fast_clock_out_pin),
  .fast_base_is_48m(fast_base_is_48m),
  .serial_pullup_enable(serial_pullup_enable),
  .serial_slave_addr(serial_slave_addr));

// *** clock_serial_config_tb.sv ***
// self-checking bench for the clock and serial configuration bank
`timescale 1ns/1ps
module clock_serial_config_tb;
  import clkcfg_pkg::*;
  // ****************************************************************
  // design, stimulus and answer checking
  // ****************************************************************
  localparam int SF = 5;
  localparam int SO = 20;
  localparam int DIV_TAB [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
  logic        aclk = 1'b0;
  logic        aresetn, sb_n, bat_n, strap, mult, slow, fast, base48, pu, pu2;
  logic        awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [9:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  bresp, rresp;
  logic [6:0]  sadr, sadr2;
  logic [3:0]  ws;
  logic [7:0]  v, s;
  logic        mg_e = 1'b1;
  logic        st_e = 1'b1;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          cnt;
  always #12.5 aclk = ~aclk;
  clock_serial_config #(.SLOW_FAST_HALF(SF), .SLOW_ONE_HALF(SO))
    clock_serial_config_i (
    .aclk(aclk), .aresetn(aresetn), .standby_reset_n(sb_n),
    .battery_reset_n(bat_n), .ext_clock_strap_pin(strap),
    .multiplier_locked_pin(mult), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .slow_clock_out_pin(slow), .fast_clock_out_pin(fast),
    .fast_base_is_48m(base48), .serial_pullup_enable(pu),
    .serial_slave_addr(sadr));
  // same stimulus into the variant that has no serial bus
  clock_serial_config #(.HAS_SERIAL_BUS(1'b0), .SLOW_FAST_HALF(SF),
    .SLOW_ONE_HALF(SO)) clock_serial_config_i2 (
    .aclk(aclk), .aresetn(aresetn), .standby_reset_n(sb_n),
    .battery_reset_n(bat_n), .ext_clock_strap_pin(strap),
    .multiplier_locked_pin(mult), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rr),
    .slow_clock_out_pin(), .fast_clock_out_pin(),
    .fast_base_is_48m(), .serial_pullup_enable(pu2),
    .serial_slave_addr(sadr2));
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] cfg(input logic [7:0] x);
    return {x[7:5], mg_e, st_e, x[2:0]};
  endfunction
  // ready raised after a random 0 to 3 cycles, so the slave may have to hold its answer
  task automatic xfer(input bit w, input logic [9:0] a, input logic [7:0] d,
                      input logic [1:0] er = RESP_OKAY,
                      input logic [3:0] ms = 4'hf);
    bit ga, gw, gd, done;
    int dly;
    done = 0;
    dly = $urandom_range(3);
    if (w) bq.push_back(er);
    else rq.push_back({er, 24'h0, d});
    @(posedge aclk);
    awa <= a;
    ara <= a;
    wd <= {24'h0, d};
    ws <= ms;
    awv <= w;
    wv <= w;
    arv <= !w;
    for (int k = 0; k < 50 && !done; k++) begin
      @(negedge aclk);
      ga = w ? awv && awr : arv && arr;
      gw = wv && wrdy;
      gd = w ? bv && br : rv && rr;
      @(posedge aclk);
      if (ga) awv <= 1'b0;
      if (ga) arv <= 1'b0;
      if (gw) wv <= 1'b0;
      if (k == dly) br <= w;
      if (k == dly) rr <= !w;
      if (gd) br <= 1'b0;
      if (gd) rr <= 1'b0;
      done = gd;
    end
    if (!done) chk(1'b0, "bus answer missing");
  endtask
  always @(negedge aclk) begin
    if (bv === 1'b1 && br)
      chk(bresp === bq.pop_front(), "write resp");
    if (rv === 1'b1 && rr)
      chk({rresp, rdat} === rq.pop_front(), "read");
  end
  function automatic logic pin(input bit sl);
    return sl ? slow : fast;
  endfunction
  task automatic wait_lvl(input bit sl, input logic lv);
    for (int k = 0; k < 100 && pin(sl) !== lv; k++) begin
      @(negedge aclk);
      cnt++;
    end
  endtask
  task automatic period(input bit sl, input int n);
    @(negedge aclk);
    wait_lvl(sl, 1'b0);
    wait_lvl(sl, 1'b1);
    cnt = 0;
    wait_lvl(sl, 1'b0);
    wait_lvl(sl, 1'b1);
    chk(cnt == n, "clock period");
  endtask
  task automatic steady(input logic lv);
    repeat (20) begin
      @(negedge aclk);
      chk(fast === lv, "fast clock level");
    end
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge aclk);
    {aresetn, sb_n, bat_n} <= ~m;
    repeat (8) @(posedge aclk);
    {aresetn, sb_n, bat_n} <= 3'b111;
    repeat (6) @(posedge aclk);
  endtask
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      chk(1'b0, "timeout");
      test_done();
    end
  end
  initial begin
    {aresetn, sb_n, bat_n} = 3'b000;
    {awv, wv, br, arv, rr, strap, mult} = 7'h03;
    {awa, ara, wd} = 52'h0;
    ws = 4'hf;
    void'($urandom(32'hfeb3be87));
    pulse(3'b111);
    chk(base48 === 1'b1, "strap capture");
    xfer(1'b0, CLOCK_CONFIG_ADDR, cfg(8'h00));
    xfer(1'b0, SERIAL_CONFIG_ADDR, 8'h00);
    xfer(1'b0, 10'h3f0, 8'h00, RESP_SLVERR);
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, CLOCK_CONFIG_ADDR, 8'(c));
      xfer(1'b0, CLOCK_CONFIG_ADDR, cfg(8'(c)));
      if (c == 0) steady(1'b1);
      else period(1'b0, DIV_TAB[c]);
    end
    // low byte strobe off: answered, nothing written
    xfer(1'b1, CLOCK_CONFIG_ADDR, 8'h00, RESP_OKAY, 4'he);
    xfer(1'b0, CLOCK_CONFIG_ADDR, cfg(8'h07));
    xfer(1'b1, CLOCK_CONFIG_ADDR, 8'h23);
    steady(1'b0);
    xfer(1'b1, CLOCK_CONFIG_ADDR, 8'h00);
    period(1'b1, 2 * SF);
    xfer(1'b1, CLOCK_CONFIG_ADDR, 8'h40);
    period(1'b1, 2 * SO);
    v = 8'($urandom()) & 8'h67;
    xfer(1'b1, CLOCK_CONFIG_ADDR, v);
    xfer(1'b1, CLOCK_CONFIG_ADDR, v | 8'h80);
    xfer(1'b1, CLOCK_CONFIG_ADDR, ~v & 8'h67);
    xfer(1'b0, CLOCK_CONFIG_ADDR, cfg(v | 8'h80));
    xfer(1'b1, SERIAL_LOCK_CTL_ADDR, 8'h01);
    pulse(3'b100);
    xfer(1'b0, CLOCK_CONFIG_ADDR, cfg(v | 8'h80));
    xfer(1'b1, SERIAL_LOCK_CTL_ADDR, 8'h00);
    pulse(3'b100);
    xfer(1'b0, CLOCK_CONFIG_ADDR, cfg(v));
    xfer(1'b1, CLOCK_CONFIG_ADDR, v | 8'h80);
    xfer(1'b1, SERIAL_LOCK_CTL_ADDR, 8'h02);
    xfer(1'b0, SERIAL_LOCK_CTL_ADDR, 8'h00);
    xfer(1'b1, CLOCK_CONFIG_ADDR, 8'h02);
    xfer(1'b1, 10'h3f0, 8'hff, RESP_SLVERR);
    xfer(1'b0, CLOCK_CONFIG_ADDR, cfg(8'h02));
    s = 8'($urandom()) | 8'h01;
    xfer(1'b1, SERIAL_CONFIG_ADDR, s);
    xfer(1'b1, SERIAL_CONFIG_ADDR, ~s);
    xfer(1'b0, SERIAL_CONFIG_ADDR, s);
    chk({pu, sadr} === s, "serial outputs");
    chk({pu2, sadr2} === 8'h00, "serial variant");
    strap <= 1'b0;
    st_e = 1'b0;
    pulse(3'b010);
    chk(base48 === 1'b0, "strap capture");
    xfer(1'b0, CLOCK_CONFIG_ADDR, cfg(8'h01));
    xfer(1'b0, SERIAL_CONFIG_ADDR, s);
    pulse(3'b001);
    xfer(1'b0, SERIAL_CONFIG_ADDR, 8'h00);
    chk({pu, sadr} === 8'h00, "serial outputs");
    mult <= 1'b0;
    mg_e = 1'b0;
    repeat (6) @(posedge aclk);
    xfer(1'b0, CLOCK_CONFIG_ADDR, cfg(8'h01));
    test_done();
  end
endmodule
